// File: bench/testbench.sv
// self-checking bench: converter and receiver ends joined over the link interface
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] SELS [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
		4'he, 4'hf};
	// row, complex, ratio column, converter latency, link latency
	localparam int LAT_TAB [5][5] = '{'{0, 0, 0, 31, 82}, '{0, 0, 1, 31, 44},
		'{4, 1, 3, 162, 50}, '{16, 1, 6, 1594, 97}, '{1, 0, 4, 90, 7}};
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [15:0] adc_sample;
	logic [tpg_pkg::NUM_DDC-1:0][15:0] ddc_i;
	logic [tpg_pkg::NUM_DDC-1:0][15:0] ddc_q;
	logic ddc_mode, complex_sel, start, stop, rd, hold_adc;
	logic [4:0] dec_mode;
	logic [2:0] ml_ratio;
	logic [3:0] sel;
	logic [1:0] pt;
	logic [tpg_pkg::NUM_DDC-1:0] ddc_en;
	logic [15:0] rd_addr;
	logic busy, test_on, rd_vld, rx_vld;
	logic [7:0] rd_data;
	logic [15:0] rx_word;
	logic [11:0] latency;
	logic [15:0] obs [20];
	logic vld [20];
	logic [15:0] e [12];
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;

	tpg_if link ();
	tpg_dev i_tpg_dev (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link),
		.adc_sample_i(adc_sample), .ddc_i_i(ddc_i), .ddc_q_i(ddc_q), .ddc_mode_i(ddc_mode),
		.complex_i(complex_sel), .decimation_ratio_mode_i(dec_mode), .ml_ratio_i(ml_ratio));
	tpg_host i_tpg_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link), .start_i(start),
		.stop_i(stop), .sel_i(sel), .pt_i(pt), .ddc_mode_i(ddc_mode), .ddc_en_i(ddc_en),
		.rd_i(rd), .rd_addr_i(rd_addr), .busy_o(busy), .test_on_o(test_on),
		.rd_data_o(rd_data), .rd_vld_o(rd_vld), .rx_word_o(rx_word), .rx_vld_o(rx_vld),
		.latency_o(latency));
	tpg_properties i_tpg_properties (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.smp_vld(link.smp_vld), .smp_q(link.smp_q), .sym10(link.sym10),
		.sym_vld(link.sym_vld), .oct8(link.oct8), .oct_vld(link.oct_vld));

	always #20 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		num_checks++;
		if (seen !== expv) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	// random analog data keeps flowing while hold_adc is low so a test pattern can never match it by accident
	task automatic step(input int n = 1);
		repeat (n) begin
			@(negedge clk_sys_i);
			if (!hold_adc) begin
				adc_sample = 16'($urandom());
				ddc_i = {16'($urandom()), 32'($urandom())};
				ddc_q = {16'($urandom()), 32'($urandom())};
			end
		end
	endtask

	task automatic rd_reg(input logic [15:0] a, output logic [7:0] got);
		int n;
		rd = 1'b1;
		rd_addr = a;
		step();
		rd = 1'b0;
		n = 0;
		while (rd_vld !== 1'b1 && n < 8) begin
			step();
			n++;
		end
		check({15'h0000, rd_vld}, 16'h0001);
		got = rd_data;
	endtask

	task automatic make_exp(input logic [3:0] s, input int w, input logic [15:0] x0);
		logic [30:0] st;
		logic fb;
		int n;
		int t;
		n = 1;
		t = 0;
		st = '0;
		if (s >= 4'h3 && s <= 4'h7) begin
			n = tpg_pkg::PN_N[s - 3];
			t = tpg_pkg::PN_T[s - 3];
			st = tpg_pkg::PN_SEED[s - 3];
		end
		for (int k = 0; k < 12; k++) begin
			case (s)
				4'h1: e[k] = (k % 2 == 0 ? 16'h5555 : 16'haaaa) >> (16 - w);
				4'h2: e[k] = (k % 2 == 0 ? 16'h0000 : 16'hffff) >> (16 - w);
				4'h8: e[k] = 16'(x0 + k) & (16'hffff >> (16 - w));
				4'he, 4'hf: e[k] = 16'h0000;
				default: begin
					e[k] = 16'h0000;
					for (int b = 0; b < w; b++) begin
						e[k] = {e[k][14:0], st[0]};
						fb = st[0] ^ st[t];
						st = st >> 1;
						st[n - 1] = fb;
					end
				end
			endcase
		end
	endtask

	// user words are never programmed here, so both user modes expect zero words
	task automatic run_case(input logic [3:0] s, input logic [1:0] p, input logic dm);
		int n;
		int o;
		logic [7:0] got;
		sel = s;
		pt = p;
		ddc_mode = dm;
		start = 1'b1;
		step();
		start = 1'b0;
		n = 0;
		while (!(link.reg_wr === 1'b1 && link.reg_addr === tpg_pkg::ADDR_LINK_CTRL) && n < 20) begin
			step();
			n++;
		end
		for (int i = 0; i < 20; i++) begin
			step();
			obs[i] = p == 2'd1 ? {6'h00, link.sym10} : p == 2'd2 ? {8'h00, link.oct8} : link.smp_i[0];
			vld[i] = p == 2'd1 ? link.sym_vld : p == 2'd2 ? link.oct_vld : 1'b1;
		end
		o = p == 2'd0 && s == 4'h8 ? 4 : 0;
		while (p != 2'd0 && o < 7 && vld[o] !== 1'b1) o++;
		make_exp(s, p == 2'd1 ? 10 : p == 2'd2 ? 8 : 16, obs[o]);
		while (p == 2'd0 && s != 4'h8 && o < 7 && obs[o] !== e[0]) o++;
		for (int k = 0; k < 12; k++) check(obs[o + k], e[k]);
		if (p == 2'd0) begin
			check(rx_word, obs[18]);
			for (int c = 1; c < tpg_pkg::NUM_DDC; c++) check(link.smp_i[c], link.smp_i[0]);
			for (int c = 0; c < tpg_pkg::NUM_DDC; c++) check(link.smp_q[c], 16'h0000);
		end
		if (p == 2'd0 && (s == 4'h6 || s == 4'h4)) begin
			check(obs[o], s == 4'h6 ? 16'h496f : 16'hff5c);
			check(obs[o + 1], s == 4'h6 ? 16'hc9a9 : 16'h0029);
		end
		check({15'h0000, test_on}, 16'h0001);
		rd_reg(tpg_pkg::ADDR_LINK_CTRL, got);
		check({8'h00, got}, {8'h00, 2'b00, p, s});
	endtask

	task automatic stop_test();
		stop = 1'b1;
		step();
		check({15'h0000, busy}, 16'h0001);
		stop = 1'b0;
		step(6);
	endtask

	initial begin
		logic [7:0] got;
		void'($urandom(55));
		{hold_adc, ddc_mode, complex_sel, start, stop, rd} = 6'h00;
		{adc_sample, ddc_i, ddc_q} = '0;
		{dec_mode, ml_ratio, sel, pt, ddc_en, rd_addr} = '0;
		step(20);
		rstn_i = 1'b1;
		step(2);
		check({15'h0000, rx_vld}, 16'h0001);
		rd_reg(tpg_pkg::ADDR_LINK_CTRL, got);
		check({8'h00, got}, 16'h0000);
		rd_reg(16'h0100, got);
		check({8'h00, got}, 16'h0000);
		$display("test register reset done");
		for (int i = 0; i < 5; i++) begin
			dec_mode = 5'(LAT_TAB[i][0]);
			complex_sel = LAT_TAB[i][1] != 0;
			ml_ratio = 3'(LAT_TAB[i][2]);
			step(4);
			check({5'h00, link.lat_dsp}, 16'(LAT_TAB[i][3]));
			check({7'h00, link.lat_link}, 16'(LAT_TAB[i][4]));
			check({4'h0, latency}, 16'(LAT_TAB[i][3] + LAT_TAB[i][4]));
		end
		$display("test latency done");
		for (int i = 0; i < 10; i++) begin
			for (int p = 0; p < 3; p++) begin
				run_case(SELS[i], 2'(p), 1'b0);
				stop_test();
			end
		end
		$display("test patterns done");
		hold_adc = 1'b1;
		step(4);
		check(link.smp_i[0], adc_sample);
		check({15'h0000, test_on}, 16'h0000);
		rd_reg(tpg_pkg::ADDR_CONFIG, got);
		check({8'h00, got}, 16'h0000);
		rd_reg(tpg_pkg::ADDR_LINK_CTRL, got);
		check({8'h00, got}, 16'h0000);
		$display("test soft reset done");
		sel = 4'h9;
		pt = 2'd0;
		start = 1'b1;
		step();
		start = 1'b0;
		step(8);
		check(link.smp_i[0], adc_sample);
		stop_test();
		hold_adc = 1'b0;
		sel = 4'hb;
		pt = 2'd1;
		start = 1'b1;
		step();
		start = 1'b0;
		step(8);
		check({15'h0000, link.sym_vld}, 16'h0000);
		stop_test();
		$display("test reserved selectors done");
		ddc_en = 3'b111;
		run_case(4'h1, 2'd0, 1'b1);
		for (int c = 0; c < tpg_pkg::NUM_DDC; c++) begin
			rd_reg(16'(tpg_pkg::ADDR_DDC0 + c * tpg_pkg::DDC_STRIDE), got);
			check({15'h0000, got[0]}, 16'h0001);
		end
		stop_test();
		$display("test downconverter mode done");
		ddc_en = 3'b000;
		for (int i = 0; i < 4; i++) begin
			run_case(SELS[$urandom_range(9, 0)], 2'($urandom_range(2, 0)), 1'b0);
			stop_test();
		end
		$display("test random cases done");
		tally_and_finish();
	end
endmodule

// File: bench/tpg_properties.sv
// concurrent checks on the link between the converter end and the receiver end
module tpg_properties (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// register port
	input wire logic reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	// stream
	input wire logic smp_vld,
	input wire logic [tpg_pkg::NUM_DDC-1:0][15:0] smp_q,
	input wire logic [9:0] sym10,
	input wire logic sym_vld,
	input wire logic [7:0] oct8,
	input wire logic oct_vld
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	logic [3:0] sel_reg;
	logic cfg_wr;
	logic sel_ok;
	logic sel_rsv;
	logic soft_wr;
	assign cfg_wr = reg_wr && reg_addr == tpg_pkg::ADDR_LINK_CTRL;
	assign sel_ok = reg_wdata[3:0] != 4'h0 && (reg_wdata[3:0] <= 4'h8 || reg_wdata[3:0] >= 4'he);
	assign sel_rsv = reg_wdata[3:0] > 4'h8 && reg_wdata[3:0] < 4'he;
	assign soft_wr = reg_wr && reg_addr == tpg_pkg::ADDR_CONFIG
		&& reg_wdata == tpg_pkg::SOFT_RESET_VAL;

	// remembers the last selector so pattern checks know what should be running
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_reg <= 4'h0;
		end else if (cfg_wr) begin
			sel_reg <= reg_wdata[3:0];
		end
	end

	chk_symbol_start: assert property (cfg_wr && reg_wdata[5:4] == 2'b01 && sel_ok
		&& !sym_vld && !oct_vld |-> ##[1:3] sym_vld) else $error("symbol test did not start");
	chk_octet_start: assert property (cfg_wr && reg_wdata[5:4] == 2'b10 && sel_ok
		&& !sym_vld && !oct_vld |-> ##[1:3] oct_vld) else $error("octet test did not start");
	chk_reserved_quiet: assert property (cfg_wr && reg_wdata[5:4] == 2'b01 && sel_rsv
		&& !sym_vld |=> !sym_vld [*4]) else $error("reserved selector made symbols");
	chk_soft_reset_stop: assert property (soft_wr |-> ##[1:3] (!sym_vld && !oct_vld))
		else $error("soft reset left a test running");
	chk_point_exclusive: assert property (!(sym_vld && oct_vld))
		else $error("two injection points active");
	chk_symbol_idle: assert property (!sym_vld |-> sym10 == 10'h000)
		else $error("symbol not zero while idle");
	chk_octet_idle: assert property (!oct_vld |-> oct8 == 8'h00)
		else $error("octet not zero while idle");
	chk_alt_symbols: assert property (sym_vld && $past(sym_vld)
		&& (sel_reg == tpg_pkg::SEL_CHECK || sel_reg == tpg_pkg::SEL_TOGGLE)
		|-> sym10 == ~$past(sym10)) else $error("symbols did not alternate");
	chk_octet_ramp: assert property (oct_vld && $past(oct_vld) && sel_reg == tpg_pkg::SEL_RAMP
		|-> oct8 == 8'($past(oct8) + 8'h01)) else $error("octet ramp did not step by one");
	chk_pn_first_symbol: assert property ($rose(sym_vld)
		&& (sel_reg == tpg_pkg::SEL_PN9 || sel_reg == tpg_pkg::SEL_PN23)
		|-> sym10 == (sel_reg == tpg_pkg::SEL_PN9 ? 10'h125 : 10'h3fd))
		else $error("first pn symbol wrong");
	chk_q_zero_test: assert property (sym_vld || oct_vld |-> smp_q == '0)
		else $error("quadrature output carried data during test");
	chk_stream_steady: assert property ($past(smp_vld) |-> smp_vld)
		else $error("stream valid dropped");

	cover property ($rose(sym_vld));
	cover property ($rose(oct_vld));
	cover property (soft_wr);
endmodule

// File: design/tpg_dev.sv
// converter end: registers, pattern generators and output stream
//
// Overview of operation
// R1 - test mode disconnects analog, pattern goes out
// R2 - either pn reset bit restarts pn generators
// R3 - patterns ignore analog input, need encode clock
// R4 - software enables test per active downconverter
// R5 - downconverter mode: only in-phase carries pattern
// R6 - leaving test needs self-clearing soft reset
// R7 - sample test bit sends raw converter samples
// R8 - four-bit pattern selector, two-bit injection point
// R9 - off, checkerboard, and word toggle patterns
// R10 - pn31 and pn23 from their seeds
// R11 - pn15, pn9 and pn7 sequences
// R12 - ramp wraps at injection word width
// R13 - four user words repeat forever
// R14 - four user words once, then zeros
// R15 - sample point: one word per frame
// R16 - pn9 and pn23 sample words match tables
// R17 - fixed converter plus dsp latency per mode
// R18 - fixed link latency per mode and ratio
// R19 - receiver uses latencies for deterministic timing
// R20 - point 01 sends 10-bit symbol forms
// R21 - point 10 sends 8-bit octet forms
// R22 - reserved selectors pass normal data
// R23 - generators step once per output word
module tpg_dev (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// link to the receiver
	tpg_if.dev link,
	// converter datapath
	input wire logic [15:0] adc_sample_i,
	input wire logic [tpg_pkg::NUM_DDC-1:0][15:0] ddc_i_i,
	input wire logic [tpg_pkg::NUM_DDC-1:0][15:0] ddc_q_i,
	// application mode
	input wire logic ddc_mode_i,
	input wire logic complex_i,
	input wire logic [4:0] decimation_ratio_mode_i,
	input wire logic [2:0] ml_ratio_i
);
	logic [7:0] config_reg;
	logic [7:0] conv_ctrl_reg;
	logic [7:0] smp_test_reg;
	logic [7:0] link_ctrl_reg;
	logic [7:0] user_pattern_word_reg [tpg_pkg::UP_BYTES];
	logic [tpg_pkg::NUM_DDC-1:0] ddc_test_reg;
	logic [3:0] act_sel_reg;
	logic [1:0] act_pt_reg;
	logic [30:0] pn_reg [tpg_pkg::NUM_PN];
	logic [46:0] pn_next [tpg_pkg::NUM_PN];
	logic [15:0] ramp_reg;
	logic one_done_reg;
	logic soft_rst;
	logic wr_ok;
	logic link_on;
	logic test_on;
	logic pn_rst;
	logic [3:0] sel;
	logic [1:0] pt;
	int nbits;
	logic [15:0] mask;
	logic [15:0] up_word;
	logic [15:0] pat_word;
	logic [7:0] rd_mux;
	logic [15:0] up_off;
	assign soft_rst = (config_reg == tpg_pkg::SOFT_RESET_VAL);
	assign wr_ok = link.reg_wr && !soft_rst;
	assign up_off = link.reg_addr - tpg_pkg::ADDR_UP_FIRST;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			config_reg <= tpg_pkg::REG_RESET;
		end else if (soft_rst) begin
			config_reg <= tpg_pkg::REG_RESET; // R6
		end else if (link.reg_wr && link.reg_addr == tpg_pkg::ADDR_CONFIG) begin
			config_reg <= link.reg_wdata;
		end
	end
	// user pattern words survive a soft reset so a test can be rerun without reloading
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			conv_ctrl_reg <= tpg_pkg::REG_RESET;
			smp_test_reg <= tpg_pkg::REG_RESET;
			link_ctrl_reg <= tpg_pkg::REG_RESET;
			ddc_test_reg <= '0;
			for (int b = 0; b < tpg_pkg::UP_BYTES; b++) begin
				user_pattern_word_reg[b] <= tpg_pkg::REG_RESET;
			end
		end else if (soft_rst) begin
			conv_ctrl_reg <= tpg_pkg::REG_RESET;
			smp_test_reg <= tpg_pkg::REG_RESET;
			link_ctrl_reg <= tpg_pkg::REG_RESET;
			ddc_test_reg <= '0;
		end else if (wr_ok) begin
			case (link.reg_addr)
				tpg_pkg::ADDR_CONV_CTRL: conv_ctrl_reg <= link.reg_wdata;
				tpg_pkg::ADDR_SMP_TEST: smp_test_reg <= link.reg_wdata;
				tpg_pkg::ADDR_LINK_CTRL: link_ctrl_reg <= link.reg_wdata;
				default: ;
			endcase
			if (up_off < 16'(tpg_pkg::UP_BYTES)) begin
				user_pattern_word_reg[up_off[2:0]] <= link.reg_wdata;
			end
			for (int c = 0; c < tpg_pkg::NUM_DDC; c++) begin
				if (link.reg_addr == tpg_pkg::ADDR_DDC0 + 16'(c) * tpg_pkg::DDC_STRIDE) begin
					ddc_test_reg[c] <= link.reg_wdata[tpg_pkg::DDC_TEST_BIT]; // R4
				end
			end
		end
	end
	// writing zero does not stop a running test; only the soft reset or a write of a reserved selector or point returns to normal data
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			act_sel_reg <= tpg_pkg::SEL_OFF;
			act_pt_reg <= tpg_pkg::PT_SAMPLE;
		end else if (soft_rst) begin
			act_sel_reg <= tpg_pkg::SEL_OFF; // R6
			act_pt_reg <= tpg_pkg::PT_SAMPLE;
		end else if (wr_ok && link.reg_addr == tpg_pkg::ADDR_LINK_CTRL &&
			link.reg_wdata[3:0] != tpg_pkg::SEL_OFF) begin
			act_sel_reg <= link.reg_wdata[tpg_pkg::SEL_LSB +: 4]; // R8
			act_pt_reg <= link.reg_wdata[tpg_pkg::PT_LSB +: 2];
		end
	end
	always_comb begin
		link_on = tpg_pkg::sel_defined(act_sel_reg) && act_pt_reg != 2'h3; // R22
		test_on = link_on || tpg_pkg::sel_defined(conv_ctrl_reg[3:0]);
		sel = link_on ? act_sel_reg : conv_ctrl_reg[3:0];
		pt = link_on ? act_pt_reg : tpg_pkg::PT_SAMPLE;
		case (pt)
			tpg_pkg::PT_PHY: nbits = tpg_pkg::W_PHY; // R20
			tpg_pkg::PT_SCR: nbits = tpg_pkg::W_SCR; // R21
			default: nbits = tpg_pkg::W_SAMPLE; // R15
		endcase
		pn_rst = !test_on || soft_rst || conv_ctrl_reg[tpg_pkg::PN_RST_BIT_A] ||
			conv_ctrl_reg[tpg_pkg::PN_RST_BIT_B]; // R2
		for (int g = 0; g < tpg_pkg::NUM_PN; g++) begin
			pn_next[g] = tpg_pkg::pn_step(pn_reg[g], tpg_pkg::PN_N[g], tpg_pkg::PN_T[g], nbits);
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int g = 0; g < tpg_pkg::NUM_PN; g++) begin
				pn_reg[g] <= tpg_pkg::PN_SEED[g];
			end
		end else begin
			for (int g = 0; g < tpg_pkg::NUM_PN; g++) begin
				if (pn_rst) begin
					pn_reg[g] <= tpg_pkg::PN_SEED[g]; // R10
				end else begin
					pn_reg[g] <= pn_next[g][46:16]; // R23
				end
			end
		end
	end
	// the ramp counter doubles as checkerboard phase and user word index
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ramp_reg <= 16'h0000;
			one_done_reg <= 1'b0;
		end else if (!test_on || soft_rst) begin
			ramp_reg <= 16'h0000;
			one_done_reg <= 1'b0;
		end else begin
			ramp_reg <= ramp_reg + 16'h0001; // R23
			if (ramp_reg[1:0] == 2'h3) begin
				one_done_reg <= 1'b1; // R14
			end
		end
	end
	always_comb begin
		mask = tpg_pkg::word_mask(nbits);
		up_word = {user_pattern_word_reg[{ramp_reg[1:0], 1'b0}],
			user_pattern_word_reg[{ramp_reg[1:0], 1'b1}]};
		case (sel)
			tpg_pkg::SEL_CHECK: pat_word = (ramp_reg[0] ? tpg_pkg::CHECK_B : tpg_pkg::CHECK_A); // R9
			tpg_pkg::SEL_TOGGLE: pat_word = (ramp_reg[0] ? tpg_pkg::TOGGLE_B : tpg_pkg::TOGGLE_A); // R9
			tpg_pkg::SEL_PN31: pat_word = pn_next[0][15:0]; // R10
			tpg_pkg::SEL_PN23: pat_word = pn_next[1][15:0]; // R16
			tpg_pkg::SEL_PN15: pat_word = pn_next[2][15:0]; // R11
			tpg_pkg::SEL_PN9: pat_word = pn_next[3][15:0]; // R16
			tpg_pkg::SEL_PN7: pat_word = pn_next[4][15:0]; // R11
			tpg_pkg::SEL_RAMP: pat_word = ramp_reg; // R12
			tpg_pkg::SEL_USER_REP: pat_word = up_word >> (tpg_pkg::W_SAMPLE - nbits); // R13
			tpg_pkg::SEL_USER_ONE: pat_word = one_done_reg ? 16'h0000 :
				up_word >> (tpg_pkg::W_SAMPLE - nbits); // R14
			default: pat_word = 16'h0000;
		endcase
		pat_word = pat_word & mask;
	end
	// with analog disconnected, lanes without a pattern read zero rather than stale data
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link.smp_vld <= 1'b0;
			link.smp_i <= '0;
			link.smp_q <= '0;
		end else begin
			link.smp_vld <= 1'b1;
			for (int c = 0; c < tpg_pkg::NUM_DDC; c++) begin
				if (smp_test_reg[tpg_pkg::SMP_TEST_BIT]) begin
					link.smp_i[c] <= adc_sample_i; // R7
					link.smp_q[c] <= 16'h0000;
				end else if (test_on) begin
					link.smp_q[c] <= 16'h0000; // R5
					if (pt == tpg_pkg::PT_SAMPLE && (!ddc_mode_i || ddc_test_reg[c])) begin
						link.smp_i[c] <= pat_word; // R15
					end else begin
						link.smp_i[c] <= 16'h0000; // R1
					end
				end else begin
					link.smp_i[c] <= ddc_mode_i ? ddc_i_i[c] : adc_sample_i; // R3
					link.smp_q[c] <= ddc_mode_i ? ddc_q_i[c] : 16'h0000;
				end
			end
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link.sym10 <= 10'h000;
			link.sym_vld <= 1'b0;
			link.oct8 <= 8'h00;
			link.oct_vld <= 1'b0;
		end else begin
			link.sym_vld <= test_on && pt == tpg_pkg::PT_PHY;
			link.sym10 <= (test_on && pt == tpg_pkg::PT_PHY) ? pat_word[9:0] : 10'h000; // R20
			link.oct_vld <= test_on && pt == tpg_pkg::PT_SCR;
			link.oct8 <= (test_on && pt == tpg_pkg::PT_SCR) ? pat_word[7:0] : 8'h00; // R21
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link.lat_dsp <= 11'h000;
			link.lat_link <= 9'h000;
		end else if (decimation_ratio_mode_i < 5'(tpg_pkg::LAT_ROWS) &&
			ml_ratio_i < 3'(tpg_pkg::LAT_RATIOS)) begin
			link.lat_dsp <= complex_i ? 11'(tpg_pkg::DSP_LAT_CPLX[decimation_ratio_mode_i]) :
				11'(tpg_pkg::DSP_LAT_REAL[decimation_ratio_mode_i]); // R17
			link.lat_link <= 9'(tpg_pkg::LINK_LAT[decimation_ratio_mode_i][ml_ratio_i]); // R18
		end else begin
			link.lat_dsp <= 11'h000;
			link.lat_link <= 9'h000;
		end
	end
	always_comb begin
		rd_mux = 8'h00;
		case (link.reg_addr)
			tpg_pkg::ADDR_CONFIG: rd_mux = config_reg;
			tpg_pkg::ADDR_CONV_CTRL: rd_mux = conv_ctrl_reg;
			tpg_pkg::ADDR_SMP_TEST: rd_mux = smp_test_reg;
			tpg_pkg::ADDR_LINK_CTRL: rd_mux = link_ctrl_reg;
			default: ;
		endcase
		if (up_off < 16'(tpg_pkg::UP_BYTES)) begin
			rd_mux = user_pattern_word_reg[up_off[2:0]];
		end
		for (int c = 0; c < tpg_pkg::NUM_DDC; c++) begin
			if (link.reg_addr == tpg_pkg::ADDR_DDC0 + 16'(c) * tpg_pkg::DDC_STRIDE) begin
				rd_mux = {7'h00, ddc_test_reg[c]};
			end
		end
	end
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link.reg_rvalid <= 1'b0;
			link.reg_rdata <= 8'h00;
		end else begin
			link.reg_rvalid <= link.reg_rd;
			link.reg_rdata <= link.reg_rd ? rd_mux : 8'h00;
		end
	end
endmodule

// File: design/tpg_host.sv
// receiver end: configures test modes over the register port and captures the stream
module tpg_host (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// link to the converter
	tpg_if.host link,
	// test control
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [3:0] sel_i,
	input wire logic [1:0] pt_i,
	input wire logic ddc_mode_i,
	input wire logic [tpg_pkg::NUM_DDC-1:0] ddc_en_i,
	// register read
	input wire logic rd_i,
	input wire logic [15:0] rd_addr_i,
	// status and data
	output logic busy_o,
	output logic test_on_o,
	output logic [7:0] rd_data_o,
	output logic rd_vld_o,
	output logic [15:0] rx_word_o,
	output logic rx_vld_o,
	output logic [11:0] latency_o
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000, H_DDC = 3'b001, H_SEL = 3'b011,
		H_RUN = 3'b010, H_OFF = 3'b110, H_RST = 3'b111
	} tpg_host_st_type;

	tpg_host_st_type state_reg;
	logic [1:0] ch_reg;
	logic [7:0] ctrl_reg;
	logic [tpg_pkg::NUM_DDC-1:0] en_reg;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= H_IDLE;
			ch_reg <= 2'h0;
			ctrl_reg <= tpg_pkg::REG_RESET;
			en_reg <= '0;
			busy_o <= 1'b0;
			test_on_o <= 1'b0;
			link.reg_wr <= 1'b0;
			link.reg_rd <= 1'b0;
			link.reg_addr <= 16'h0000;
			link.reg_wdata <= 8'h00;
		end else begin
			link.reg_wr <= 1'b0;
			link.reg_rd <= 1'b0;
			case (state_reg)
				H_IDLE: begin
					if (start_i) begin
						ctrl_reg <= {2'b00, pt_i, sel_i};
						en_reg <= ddc_en_i;
						ch_reg <= 2'h0;
						busy_o <= 1'b1;
						state_reg <= ddc_mode_i ? H_DDC : H_SEL;
					end else if (rd_i) begin
						link.reg_rd <= 1'b1;
						link.reg_addr <= rd_addr_i;
					end
				end
				H_DDC: begin
					link.reg_wr <= 1'b1;
					link.reg_addr <= tpg_pkg::ADDR_DDC0 + 16'(ch_reg) * tpg_pkg::DDC_STRIDE;
					link.reg_wdata <= en_reg[ch_reg] ? tpg_pkg::DDC_TEST_ON : tpg_pkg::REG_RESET; // R4
					ch_reg <= ch_reg + 2'h1;
					if (ch_reg == 2'(tpg_pkg::NUM_DDC - 1)) begin
						state_reg <= H_SEL;
					end
				end
				H_SEL: begin
					link.reg_wr <= 1'b1;
					link.reg_addr <= tpg_pkg::ADDR_LINK_CTRL;
					link.reg_wdata <= ctrl_reg;
					test_on_o <= 1'b1;
					busy_o <= 1'b0;
					state_reg <= H_RUN;
				end
				H_RUN: begin
					if (stop_i) begin
						busy_o <= 1'b1;
						state_reg <= H_OFF;
					end else if (rd_i) begin
						link.reg_rd <= 1'b1;
						link.reg_addr <= rd_addr_i;
					end
				end
				H_OFF: begin
					link.reg_wr <= 1'b1;
					link.reg_addr <= tpg_pkg::ADDR_LINK_CTRL;
					link.reg_wdata <= tpg_pkg::REG_RESET;
					state_reg <= H_RST;
				end
				H_RST: begin
					// the zero write alone leaves the pattern running
					link.reg_wr <= 1'b1;
					link.reg_addr <= tpg_pkg::ADDR_CONFIG;
					link.reg_wdata <= tpg_pkg::SOFT_RESET_VAL; // R6
					test_on_o <= 1'b0;
					busy_o <= 1'b0;
					state_reg <= H_IDLE;
				end
				default: begin
					busy_o <= 1'b0;
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_o <= 8'h00;
			rd_vld_o <= 1'b0;
			rx_word_o <= 16'h0000;
			rx_vld_o <= 1'b0;
			latency_o <= 12'h000;
		end else begin
			rd_vld_o <= link.reg_rvalid;
			if (link.reg_rvalid) begin
				rd_data_o <= link.reg_rdata;
			end
			rx_vld_o <= link.smp_vld;
			rx_word_o <= link.smp_i[0];
			latency_o <= 12'(link.lat_dsp) + 12'(link.lat_link); // R19
		end
	end
endmodule

// File: design/tpg_if.sv
// register access and output sample stream between the converter and its receiver
interface tpg_if;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic smp_vld;
	logic [tpg_pkg::NUM_DDC-1:0][15:0] smp_i;
	logic [tpg_pkg::NUM_DDC-1:0][15:0] smp_q;
	logic [9:0] sym10;
	logic sym_vld;
	logic [7:0] oct8;
	logic oct_vld;
	logic [10:0] lat_dsp;
	logic [8:0] lat_link;
	modport dev (
		input reg_wr, reg_rd, reg_addr, reg_wdata,
		output reg_rdata, reg_rvalid, smp_vld, smp_i, smp_q, sym10, sym_vld, oct8, oct_vld,
		output lat_dsp, lat_link
	);
	modport host (
		output reg_wr, reg_rd, reg_addr, reg_wdata,
		input reg_rdata, reg_rvalid, smp_vld, smp_i, smp_q, sym10, sym_vld, oct8, oct_vld,
		input lat_dsp, lat_link
	);
endinterface

// File: design/tpg_pkg.sv
// shared constants, types and helpers for the pattern generator and its link partner
package tpg_pkg;
	localparam int NUM_DDC = 3;
	localparam int NUM_PN = 5;
	localparam int UP_BYTES = 8;
	localparam logic [15:0] ADDR_CONFIG = 16'h0000;
	localparam logic [15:0] ADDR_DDC0 = 16'h0327;
	localparam logic [15:0] DDC_STRIDE = 16'h0020;
	localparam logic [15:0] ADDR_CONV_CTRL = 16'h0550;
	localparam logic [15:0] ADDR_UP_FIRST = 16'h0551;
	localparam logic [15:0] ADDR_SMP_TEST = 16'h0571;
	localparam logic [15:0] ADDR_LINK_CTRL = 16'h0573;
	localparam int DDC_TEST_BIT = 0;
	localparam int PN_RST_BIT_A = 4;
	localparam int PN_RST_BIT_B = 5;
	localparam int SMP_TEST_BIT = 5;
	localparam int SEL_LSB = 0;
	localparam int PT_LSB = 4;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] SOFT_RESET_VAL = 8'h81;
	localparam logic [7:0] DDC_TEST_ON = 8'h01;
	typedef enum logic [3:0] {
		SEL_OFF = 4'h0, SEL_CHECK = 4'h1, SEL_TOGGLE = 4'h2, SEL_PN31 = 4'h3,
		SEL_PN23 = 4'h4, SEL_PN15 = 4'h5, SEL_PN9 = 4'h6, SEL_PN7 = 4'h7,
		SEL_RAMP = 4'h8, SEL_USER_REP = 4'he, SEL_USER_ONE = 4'hf
	} tpg_sel_type;
	typedef enum logic [1:0] {PT_SAMPLE = 2'h0, PT_PHY = 2'h1, PT_SCR = 2'h2} tpg_pt_type;
	localparam int W_SAMPLE = 16;
	localparam int W_PHY = 10;
	localparam int W_SCR = 8;
	localparam logic [15:0] CHECK_A = 16'h5555;
	localparam logic [15:0] CHECK_B = 16'haaaa;
	localparam logic [15:0] TOGGLE_A = 16'h0000;
	localparam logic [15:0] TOGGLE_B = 16'hffff;
	// order: pn31, pn23, pn15, pn9, pn7; tap is length minus middle exponent
	localparam int PN_N [NUM_PN] = '{31, 23, 15, 9, 7};
	localparam int PN_T [NUM_PN] = '{3, 5, 1, 4, 1};
	localparam logic [30:0] PN_SEED [NUM_PN] = '{31'h0003_afff, 31'h0000_3aff,
		31'h0000_03af, 31'h0000_0092, 31'h0000_0007};
	// latency rows: full bw, x1,2,3,4,5,6,8,10,12,15,16,20,24,30,40,48; 0 = not supported
	localparam int LAT_ROWS = 17;
	localparam int LAT_RATIOS = 7;
	localparam int DSP_LAT_REAL [LAT_ROWS] = '{31, 90, 162, 212, 292, 380, 424, 552, 694,
		814, 500, 0, 1420, 1594, 0, 0, 0};
	localparam int DSP_LAT_CPLX [LAT_ROWS] = '{31, 0, 90, 102, 162, 0, 212, 292, 380,
		424, 0, 552, 694, 814, 836, 1420, 1594};
	// ratio columns: 0.125, 0.25, 0.5, 1, 2, 4, 8
	localparam int LINK_LAT [LAT_ROWS][LAT_RATIOS] = '{
		'{82, 44, 25, 14, 7, 9, 3}, '{82, 44, 25, 14, 7, 0, 0},
		'{160, 84, 46, 27, 14, 7, 0}, '{237, 124, 67, 39, 21, 11, 0},
		'{315, 164, 88, 50, 27, 14, 9}, '{0, 203, 109, 62, 43, 0, 0},
		'{0, 243, 130, 73, 39, 21, 14}, '{0, 323, 172, 96, 50, 27, 18},
		'{0, 0, 213, 119, 62, 33, 22}, '{0, 0, 255, 142, 73, 39, 27},
		'{0, 0, 318, 176, 90, 47, 33}, '{0, 0, 339, 188, 96, 50, 35},
		'{0, 0, 0, 233, 119, 62, 43}, '{0, 0, 0, 279, 142, 73, 51},
		'{0, 0, 0, 348, 176, 90, 62}, '{0, 0, 0, 0, 233, 119, 82},
		'{0, 0, 0, 0, 279, 142, 97}};

	// lsb of the state leaves first and becomes the word msb
	function automatic logic [46:0] pn_step(input logic [30:0] st, input int n, input int t,
		input int nbits);
		logic [30:0] s;
		logic [15:0] w;
		logic fb;
		s = st;
		w = 16'h0000;
		fb = 1'b0;
		for (int i = 0; i < W_SAMPLE; i++) begin
			if (i < nbits) begin
				w = {w[14:0], s[0]};
				fb = s[0] ^ s[t];
				s = s >> 1;
				s[n - 1] = fb;
			end
		end
		return {s, w};
	endfunction

	function automatic logic sel_defined(input logic [3:0] sel);
		return (sel != SEL_OFF) && ((sel <= SEL_RAMP) || (sel >= SEL_USER_REP));
	endfunction

	function automatic logic [15:0] word_mask(input int nbits);
		return 16'hffff >> (W_SAMPLE - nbits);
	endfunction
endpackage
